// >>> hw/hctr_cmd_if.sv
`timescale 1ns/1ns
`default_nettype none

interface hctr_cmd_if;
  logic                cmdWrite;
  hctr_pkg::hctr_byte_t cmdWrData;
  logic                seqEnd;
  logic [2:0]          doneVec;
  hctr_pkg::hctr_byte_t cmdBits;
  logic                ackPulse;
  logic                fifoPulse;
  logic                regResetPulse;
  logic [2:0]          startVec;
  logic                busy;

  modport seq (
    input  cmdWrite, cmdWrData, seqEnd, doneVec,
    output cmdBits, ackPulse, fifoPulse, regResetPulse, startVec, busy
  );

  modport host (
    output cmdWrite, cmdWrData, seqEnd, doneVec,
    input  cmdBits, ackPulse, fifoPulse, regResetPulse, startVec, busy
  );
endinterface : hctr_cmd_if

`default_nettype wire

// >>> hw/hctr_cmd_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "hctr_consts.svh"

module hctr_cmd_seq (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Command channel
  hctr_cmd_if.seq   cmdBus
);

  hctr_pkg::hctr_seq_e  state_q, state_d;
  hctr_pkg::hctr_byte_t cmd_q, cmd_d;
  hctr_pkg::hctr_byte_t clrMask;
  logic [1:0]           waitIdx_q, waitIdx_d;
  logic                 ack_q, ack_d;
  logic                 fifo_q, fifo_d;
  logic                 regRst_q, regRst_d;
  logic [2:0]           start_q, start_d;

  always_comb begin
    state_d   = state_q;
    waitIdx_d = waitIdx_q;
    clrMask   = `HCTR_BYTE_ZERO;
    ack_d     = 1'b0;
    fifo_d    = 1'b0;
    regRst_d  = 1'b0;
    start_d   = 3'h0;
    case (state_q)
      hctr_pkg::HCTR_SEQ_IDLE: begin
        if (cmdBus.seqEnd && (|cmd_q)) begin
          state_d = hctr_pkg::HCTR_SEQ_RUN;
        end
      end
      hctr_pkg::HCTR_SEQ_RUN: begin
        // Register reset runs last since it wipes the remaining request bits
        if (cmd_q[`HCTR_CMD_ACK]) begin
          ack_d                 = 1'b1;
          clrMask[`HCTR_CMD_ACK] = 1'b1;
        end else if (cmd_q[`HCTR_CMD_FIFO]) begin
          fifo_d                  = 1'b1;
          clrMask[`HCTR_CMD_FIFO] = 1'b1;
        end else if (cmd_q[`HCTR_CMD_FV]) begin
          start_d[`HCTR_CMD_FV] = 1'b1;
          waitIdx_d             = 2'(`HCTR_CMD_FV);
          state_d               = hctr_pkg::HCTR_SEQ_WAIT;
        end else if (cmd_q[`HCTR_CMD_PST]) begin
          start_d[`HCTR_CMD_PST] = 1'b1;
          waitIdx_d              = 2'(`HCTR_CMD_PST);
          state_d                = hctr_pkg::HCTR_SEQ_WAIT;
        end else if (cmd_q[`HCTR_CMD_ADC]) begin
          start_d[`HCTR_CMD_ADC] = 1'b1;
          waitIdx_d              = 2'(`HCTR_CMD_ADC);
          state_d                = hctr_pkg::HCTR_SEQ_WAIT;
        end else if (cmd_q[`HCTR_CMD_RESET]) begin
          regRst_d                 = 1'b1;
          clrMask[`HCTR_CMD_RESET] = 1'b1;
        end else begin
          state_d = hctr_pkg::HCTR_SEQ_IDLE;
        end
      end
      hctr_pkg::HCTR_SEQ_WAIT: begin
        if (cmdBus.doneVec[waitIdx_q]) begin
          clrMask[waitIdx_q] = 1'b1;
          state_d            = hctr_pkg::HCTR_SEQ_RUN;
        end
      end
      default: state_d = hctr_pkg::HCTR_SEQ_IDLE;
    endcase
    // Register reset empties all requests; a host set in the same cycle still wins
    if (regRst_q) begin
      clrMask = `HCTR_CNT_MAX;
    end
    cmd_d = cmd_q & ~clrMask;
    if (cmdBus.cmdWrite) begin
      cmd_d = cmd_d | cmdBus.cmdWrData; // Writing zero has no effect
    end
    cmd_d = cmd_d & ~`HCTR_CMD_RSVD_MASK;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= hctr_pkg::HCTR_SEQ_IDLE;
      cmd_q     <= `HCTR_RST_CMD;
      waitIdx_q <= 2'h0;
      ack_q     <= 1'b0;
      fifo_q    <= 1'b0;
      regRst_q  <= 1'b0;
      start_q   <= 3'h0;
    end else begin
      state_q   <= state_d;
      cmd_q     <= cmd_d;
      waitIdx_q <= waitIdx_d;
      ack_q     <= ack_d;
      fifo_q    <= fifo_d;
      regRst_q  <= regRst_d;
      start_q   <= start_d;
    end
  end

  assign cmdBus.cmdBits       = cmd_q;
  assign cmdBus.ackPulse      = ack_q;
  assign cmdBus.fifoPulse     = fifo_q;
  assign cmdBus.regResetPulse = regRst_q;
  assign cmdBus.startVec      = start_q;
  assign cmdBus.busy          = (state_q != hctr_pkg::HCTR_SEQ_IDLE);

endmodule : hctr_cmd_seq

`default_nettype wire

// >>> hw/hctr_consts.svh
`ifndef HCTR_CONSTS_SVH
`define HCTR_CONSTS_SVH

// Register offsets
`define HCTR_ADDR_CMD      16'h0057
`define HCTR_ADDR_DEB      16'h0058
`define HCTR_ADDR_FIX_HI   16'h0059
`define HCTR_ADDR_FIX_LO   16'h005a
`define HCTR_ADDR_MIN_STEP 16'h005b
`define HCTR_ADDR_REL_HI   16'h005c

// Reset values
`define HCTR_RST_CMD       8'h00
`define HCTR_RST_DEB       8'h05
`define HCTR_RST_FIX_HI    8'h03
`define HCTR_RST_FIX_LO    8'h20
`define HCTR_RST_MIN_STEP  8'h03
`define HCTR_RST_REL_HI    8'h00

// Command bit positions
`define HCTR_CMD_ACK       7
`define HCTR_CMD_FIFO      4
`define HCTR_CMD_RESET     3
`define HCTR_CMD_FV        2
`define HCTR_CMD_PST       1
`define HCTR_CMD_ADC       0
`define HCTR_CMD_RSVD_MASK 8'h60

// Debounce limit range
`define HCTR_DEB_ILLEGAL   8'hff
`define HCTR_DEB_TOP       8'hfe
`define HCTR_CNT_MAX       8'hff
`define HCTR_BYTE_ZERO     8'h00

`endif

// >>> hw/hctr_pkg.sv
package hctr_pkg;

  typedef logic [7:0] hctr_byte_t;

  typedef enum {
    HCTR_SEQ_IDLE,
    HCTR_SEQ_RUN,
    HCTR_SEQ_WAIT
  } hctr_seq_e;

  typedef enum {
    HCTR_REG_NONE,
    HCTR_REG_CMD,
    HCTR_REG_DEB,
    HCTR_REG_FIX_HI,
    HCTR_REG_FIX_LO,
    HCTR_REG_MIN_STEP,
    HCTR_REG_REL_HI
  } hctr_reg_e;

endpackage : hctr_pkg

// >>> hw/hctr_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "hctr_consts.svh"

module hctr_regs #(
  parameter int ADDR_W   = 16,
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Register port from the SPI client
  input  wire logic                spiSeqActive,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [7:0]          regWrData,
  output logic      [7:0]          regRdData,
  output logic                     regRdValid,
  // Command actions
  output logic                     flagAckPulse,
  output logic                     fifoEmptyPulse,
  output logic                     firmwareCheckStart,
  output logic                     cellSelftestStart,
  output logic                     converterSelftestStart,
  input  wire logic                firmwareCheckDone,
  input  wire logic                cellSelftestDone,
  input  wire logic                converterSelftestDone,
  output logic                     cmdBusy,
  // Pressure detection
  input  wire logic                sampleValid,
  input  wire logic [SAMPLE_W-1:0] pressureSample,
  input  wire logic                fixedCheckEnable,
  input  wire logic                relativeCheckEnable,
  input  wire logic [7:0]          relativeLimitLow,
  output logic                     fixedLimitFlag,
  output logic                     relativeLimitFlag,
  output logic                     pressureRising
);

  function automatic hctr_pkg::hctr_reg_e decodeSel(input logic [ADDR_W-1:0] a);
    hctr_pkg::hctr_reg_e s;
    s = hctr_pkg::HCTR_REG_NONE;
    if (a == ADDR_W'(`HCTR_ADDR_CMD)) begin
      s = hctr_pkg::HCTR_REG_CMD;
    end else if (a == ADDR_W'(`HCTR_ADDR_DEB)) begin
      s = hctr_pkg::HCTR_REG_DEB;
    end else if (a == ADDR_W'(`HCTR_ADDR_FIX_HI)) begin
      s = hctr_pkg::HCTR_REG_FIX_HI;
    end else if (a == ADDR_W'(`HCTR_ADDR_FIX_LO)) begin
      s = hctr_pkg::HCTR_REG_FIX_LO;
    end else if (a == ADDR_W'(`HCTR_ADDR_MIN_STEP)) begin
      s = hctr_pkg::HCTR_REG_MIN_STEP;
    end else if (a == ADDR_W'(`HCTR_ADDR_REL_HI)) begin
      s = hctr_pkg::HCTR_REG_REL_HI;
    end
    return s;
  endfunction : decodeSel

  hctr_cmd_if cmdBus ();

  hctr_cmd_seq u_seq (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .cmdBus  (cmdBus.seq)
  );

  hctr_pkg::hctr_reg_e  wrSel;
  hctr_pkg::hctr_reg_e  rdSel;
  logic                 spiPrev_q;
  logic                 seqEnd;
  logic                 cmdBusy_q;

  // Sequence end is the falling edge of the transfer-active level
  assign seqEnd = spiPrev_q & ~spiSeqActive;
  assign wrSel  = regWrite ? decodeSel(regAddr) : hctr_pkg::HCTR_REG_NONE;
  assign rdSel  = decodeSel(regAddr);

  assign cmdBus.cmdWrite  = (wrSel == hctr_pkg::HCTR_REG_CMD);
  assign cmdBus.cmdWrData = regWrData;
  assign cmdBus.seqEnd    = seqEnd;
  assign cmdBus.doneVec   = {firmwareCheckDone, cellSelftestDone, converterSelftestDone};

  assign flagAckPulse           = cmdBus.ackPulse;
  assign fifoEmptyPulse         = cmdBus.fifoPulse;
  assign firmwareCheckStart     = cmdBus.startVec[`HCTR_CMD_FV];
  assign cellSelftestStart      = cmdBus.startVec[`HCTR_CMD_PST];
  assign converterSelftestStart = cmdBus.startVec[`HCTR_CMD_ADC];
  assign cmdBusy                = cmdBusy_q;

  // Threshold registers
  hctr_pkg::hctr_byte_t deb_q, deb_d;
  hctr_pkg::hctr_byte_t fixHi_q, fixHi_d;
  hctr_pkg::hctr_byte_t fixLo_q, fixLo_d;
  hctr_pkg::hctr_byte_t minStep_q, minStep_d;
  hctr_pkg::hctr_byte_t relHi_q, relHi_d;

  always_comb begin
    deb_d     = deb_q;
    fixHi_d   = fixHi_q;
    fixLo_d   = fixLo_q;
    minStep_d = minStep_q;
    relHi_d   = relHi_q;
    if (cmdBus.regResetPulse) begin
      deb_d     = `HCTR_RST_DEB;
      fixHi_d   = `HCTR_RST_FIX_HI;
      fixLo_d   = `HCTR_RST_FIX_LO;
      minStep_d = `HCTR_RST_MIN_STEP;
      relHi_d   = `HCTR_RST_REL_HI;
    end else if (wrSel == hctr_pkg::HCTR_REG_DEB) begin
      deb_d = regWrData;
    end else if (wrSel == hctr_pkg::HCTR_REG_FIX_HI) begin
      fixHi_d = regWrData;
    end else if (wrSel == hctr_pkg::HCTR_REG_FIX_LO) begin
      fixLo_d = regWrData;
    end else if (wrSel == hctr_pkg::HCTR_REG_MIN_STEP) begin
      minStep_d = regWrData;
    end else if (wrSel == hctr_pkg::HCTR_REG_REL_HI) begin
      relHi_d = regWrData;
    end
    // Out-of-range value stays visible until the sequence closes
    if (seqEnd && (deb_d == `HCTR_DEB_ILLEGAL)) begin
      deb_d = `HCTR_DEB_TOP;
    end
  end

  // Read path
  hctr_pkg::hctr_byte_t rdData_d, rdData_q;
  logic                 rdValid_q;

  always_comb begin
    rdData_d = `HCTR_BYTE_ZERO;
    if (rdSel == hctr_pkg::HCTR_REG_CMD) begin
      rdData_d = cmdBus.cmdBits;
    end else if (rdSel == hctr_pkg::HCTR_REG_DEB) begin
      rdData_d = deb_q;
    end else if (rdSel == hctr_pkg::HCTR_REG_FIX_HI) begin
      rdData_d = fixHi_q;
    end else if (rdSel == hctr_pkg::HCTR_REG_FIX_LO) begin
      rdData_d = fixLo_q;
    end else if (rdSel == hctr_pkg::HCTR_REG_MIN_STEP) begin
      rdData_d = minStep_q;
    end else if (rdSel == hctr_pkg::HCTR_REG_REL_HI) begin
      rdData_d = relHi_q;
    end
    if (!regRead) begin
      rdData_d = rdData_q;
    end
  end

  assign regRdData  = rdData_q;
  assign regRdValid = rdValid_q;

  // Detection state
  logic [SAMPLE_W-1:0]  prev_q, prev_d;
  logic [SAMPLE_W-1:0]  base_q, base_d;
  logic                 havePrev_q, havePrev_d;
  logic                 rising_q, rising_d;
  hctr_pkg::hctr_byte_t fixCnt_q, fixCnt_d;
  hctr_pkg::hctr_byte_t relCnt_q, relCnt_d;
  logic                 fixFlag_q, fixFlag_d;
  logic                 relFlag_q, relFlag_d;
  logic [15:0]          fixedPressureLimit;
  logic [15:0]          relativeRiseLimit;
  logic [SAMPLE_W:0]    stepNeed;
  logic [SAMPLE_W-1:0]  rise;
  logic                 riseNow;

  assign fixedPressureLimit = {fixHi_q, fixLo_q};
  assign relativeRiseLimit  = {relHi_q, relativeLimitLow};
  assign stepNeed = {1'b0, prev_q} + (SAMPLE_W + 1)'(minStep_q);
  assign riseNow  = havePrev_q && ({1'b0, pressureSample} >= stepNeed);
  assign rise     = pressureSample - base_q;

  always_comb begin
    prev_d     = prev_q;
    base_d     = base_q;
    havePrev_d = havePrev_q;
    rising_d   = rising_q;
    fixCnt_d   = fixCnt_q;
    relCnt_d   = relCnt_q;
    fixFlag_d  = fixFlag_q;
    relFlag_d  = relFlag_q;
    if (cmdBus.ackPulse) begin
      fixFlag_d = 1'b0;
      relFlag_d = 1'b0;
    end
    if (sampleValid) begin
      prev_d     = pressureSample;
      havePrev_d = 1'b1;
      rising_d   = riseNow;
      if (fixedCheckEnable && (32'(pressureSample) > 32'(fixedPressureLimit))) begin
        if (fixCnt_q != `HCTR_CNT_MAX) begin
          fixCnt_d = fixCnt_q + 8'h01;
        end
        if (fixCnt_d >= deb_q) begin
          fixFlag_d = 1'b1;
        end
      end else begin
        fixCnt_d = `HCTR_BYTE_ZERO;
      end
      // Baseline follows the pressure until a rise begins
      if (!riseNow) begin
        base_d   = pressureSample;
        relCnt_d = `HCTR_BYTE_ZERO;
      end else if (relativeCheckEnable && (32'(rise) > 32'(relativeRiseLimit))) begin
        if (relCnt_q != `HCTR_CNT_MAX) begin
          relCnt_d = relCnt_q + 8'h01;
        end
        if (relCnt_d >= deb_q) begin
          relFlag_d = 1'b1;
        end
      end else begin
        relCnt_d = `HCTR_BYTE_ZERO;
      end
    end
  end

  assign fixedLimitFlag    = fixFlag_q;
  assign relativeLimitFlag = relFlag_q;
  assign pressureRising    = rising_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      spiPrev_q  <= 1'b0;
      cmdBusy_q  <= 1'b0;
      deb_q      <= `HCTR_RST_DEB;
      fixHi_q    <= `HCTR_RST_FIX_HI;
      fixLo_q    <= `HCTR_RST_FIX_LO;
      minStep_q  <= `HCTR_RST_MIN_STEP;
      relHi_q    <= `HCTR_RST_REL_HI;
      rdData_q   <= `HCTR_BYTE_ZERO;
      rdValid_q  <= 1'b0;
      prev_q     <= '0;
      base_q     <= '0;
      havePrev_q <= 1'b0;
      rising_q   <= 1'b0;
      fixCnt_q   <= `HCTR_BYTE_ZERO;
      relCnt_q   <= `HCTR_BYTE_ZERO;
      fixFlag_q  <= 1'b0;
      relFlag_q  <= 1'b0;
    end else begin
      spiPrev_q  <= spiSeqActive;
      cmdBusy_q  <= cmdBus.busy;
      deb_q      <= deb_d;
      fixHi_q    <= fixHi_d;
      fixLo_q    <= fixLo_d;
      minStep_q  <= minStep_d;
      relHi_q    <= relHi_d;
      rdData_q   <= rdData_d;
      rdValid_q  <= regRead;
      prev_q     <= prev_d;
      base_q     <= base_d;
      havePrev_q <= havePrev_d;
      rising_q   <= rising_d;
      fixCnt_q   <= fixCnt_d;
      relCnt_q   <= relCnt_d;
      fixFlag_q  <= fixFlag_d;
      relFlag_q  <= relFlag_d;
    end
  end

endmodule : hctr_regs

`default_nettype wire

// >>> verif/hctr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "hctr_consts.svh"

module hctr_host_model (
  // Clock
  input wire logic       sys_clk,
  // Register port
  output logic           spiSeqActive,
  output logic           regWrite,
  output logic           regRead,
  output logic [15:0]    regAddr,
  output logic [7:0]     regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  // Test engines
  input wire logic [2:0] startVec,
  input wire logic [7:0] doneLat,
  output logic [2:0]     doneVec
);
  logic [7:0] cnt [3];

  initial begin
    spiSeqActive = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    doneVec = 3'h0;
    cnt = '{8'h00, 8'h00, 8'h00};
  end

  // Engines finish doneLat cycles after their start
  always @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      doneVec[i] <= cnt[i] == 8'h01;
      if (startVec[i])
        cnt[i] <= doneLat;
      else if (cnt[i] != 8'h00)
        cnt[i] <= cnt[i] - 8'h01;
    end
  end

  task automatic seq(input logic on);
    @(posedge sys_clk);
    spiSeqActive <= on;
  endtask : seq

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= (a == `HCTR_ADDR_CMD) ? d & ~`HCTR_CMD_RSVD_MASK : d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdValid ? regRdData : 8'hxx;
  endtask : rd
endmodule : hctr_host_model

`default_nettype wire

// >>> verif/hctr_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "hctr_consts.svh"

module hctr_regs_monitor #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rstn,
  // Register port
  input wire logic              spiSeqActive,
  input wire logic              regRead,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regRdData,
  input wire logic              regRdValid,
  // Actions
  input wire logic              flagAckPulse,
  input wire logic              fifoEmptyPulse,
  input wire logic              firmwareCheckStart,
  input wire logic              cellSelftestStart,
  input wire logic              converterSelftestStart,
  // Detection
  input wire logic              sampleValid,
  input wire logic              fixedCheckEnable,
  input wire logic              fixedLimitFlag,
  input wire logic              pressureRising
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic       cmdRd;
  logic       badRd;
  logic [4:0] acts;
  assign cmdRd = regRead && regAddr == `HCTR_ADDR_CMD;
  assign badRd = regRead && (regAddr < `HCTR_ADDR_CMD || regAddr > `HCTR_ADDR_REL_HI);
  assign acts = {flagAckPulse, fifoEmptyPulse, firmwareCheckStart, cellSelftestStart,
                 converterSelftestStart};

  rd_valid_a: assert property (regRead |=> regRdValid)
    else $error("read not answered");
  rsvd_zero_a: assert property (cmdRd |=> regRdData[6:5] == 2'h0)
    else $error("reserved bits read nonzero");
  unmapped_zero_a: assert property (badRd |=> regRdData == 8'h00)
    else $error("unmapped read nonzero");
  act_late_a: assert property (|acts |-> !$past(spiSeqActive, 2))
    else $error("action during transfer");
  act_onehot_a: assert property ($onehot0(acts))
    else $error("two actions at once");
  fv_single_a: assert property (firmwareCheckStart |=> !firmwareCheckStart [*4])
    else $error("firmware check restarted");
  flag_hold_a: assert property (fixedLimitFlag && !flagAckPulse |=> fixedLimitFlag)
    else $error("fixed flag dropped");
  flag_cause_a: assert property ($rose(fixedLimitFlag) |-> $past(sampleValid) && $past(fixedCheckEnable))
    else $error("fixed flag without sample");
  ack_clear_a: assert property (flagAckPulse && !sampleValid |=> !fixedLimitFlag)
    else $error("ack left flag set");
  rise_cause_a: assert property ($changed(pressureRising) |-> $past(sampleValid))
    else $error("rising changed without sample");

  cover property (flagAckPulse ##1 fifoEmptyPulse);
  cover property ($rose(fixedLimitFlag));
  cover property (converterSelftestStart);
endmodule : hctr_regs_monitor

bind hctr_regs hctr_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .sys_clk(sys_clk), .rstn(rstn), .spiSeqActive(spiSeqActive), .regRead(regRead),
  .regAddr(regAddr), .regRdData(regRdData), .regRdValid(regRdValid),
  .flagAckPulse(flagAckPulse), .fifoEmptyPulse(fifoEmptyPulse),
  .firmwareCheckStart(firmwareCheckStart), .cellSelftestStart(cellSelftestStart),
  .converterSelftestStart(converterSelftestStart), .sampleValid(sampleValid),
  .fixedCheckEnable(fixedCheckEnable), .fixedLimitFlag(fixedLimitFlag),
  .pressureRising(pressureRising)
);

`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "hctr_consts.svh"

module tb;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } hctr_row_s;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        spiSeqActive, regWrite, regRead, regRdValid, cmdBusy;
  logic        flagAckPulse, fifoEmptyPulse, fixedLimitFlag, relativeLimitFlag;
  logic        sampleValid, fixedCheckEnable, relativeCheckEnable;
  logic        pressureRising;
  logic        spiPrev = 1'b0;
  logic [15:0] regAddr;
  logic [15:0] pressureSample;
  logic [7:0]  relLow;
  logic [7:0]  regWrData, regRdData, d;
  logic [7:0]  doneLat = 8'h1e;
  logic [2:0]  startVec, doneVec;
  int          cyc = 0;
  int          tEnd, tAck, tFifo;
  int          tGo [3];
  int          nFail = 0;
  int          nChecks = 0;
  logic [15:0] pv [5] = '{16'h0200, 16'h0050, 16'h0200, 16'h0202, 16'h0205};
  logic [15:0] rv [4] = '{16'h0000, 16'h0080, 16'h0180, 16'h0200};
  hctr_row_s   rows [8] = '{
    '{`HCTR_ADDR_DEB, 8'haa, 8'haa}, '{`HCTR_ADDR_DEB, 8'hfe, 8'hfe},
    '{`HCTR_ADDR_FIX_HI, 8'h5a, 8'h5a}, '{`HCTR_ADDR_FIX_LO, 8'ha5, 8'ha5},
    '{`HCTR_ADDR_MIN_STEP, 8'h81, 8'h81}, '{`HCTR_ADDR_REL_HI, 8'hc3, 8'hc3},
    '{16'h0056, 8'hff, 8'h00}, '{16'h005d, 8'h7e, 8'h00}};
  hctr_row_s   dflt [6] = '{
    '{`HCTR_ADDR_CMD, 8'h00, `HCTR_RST_CMD}, '{`HCTR_ADDR_DEB, 8'h00, `HCTR_RST_DEB},
    '{`HCTR_ADDR_FIX_HI, 8'h00, `HCTR_RST_FIX_HI}, '{`HCTR_ADDR_FIX_LO, 8'h00, `HCTR_RST_FIX_LO},
    '{`HCTR_ADDR_MIN_STEP, 8'h00, `HCTR_RST_MIN_STEP}, '{`HCTR_ADDR_REL_HI, 8'h00, `HCTR_RST_REL_HI}};

  hctr_regs dut (
    .sys_clk(sys_clk), .rstn(rstn), .spiSeqActive(spiSeqActive), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .flagAckPulse(flagAckPulse), .fifoEmptyPulse(fifoEmptyPulse),
    .firmwareCheckStart(startVec[2]), .cellSelftestStart(startVec[1]),
    .converterSelftestStart(startVec[0]), .firmwareCheckDone(doneVec[2]),
    .cellSelftestDone(doneVec[1]), .converterSelftestDone(doneVec[0]), .cmdBusy(cmdBusy),
    .sampleValid(sampleValid), .pressureSample(pressureSample),
    .fixedCheckEnable(fixedCheckEnable), .relativeCheckEnable(relativeCheckEnable),
    .relativeLimitLow(relLow), .fixedLimitFlag(fixedLimitFlag),
    .relativeLimitFlag(relativeLimitFlag), .pressureRising(pressureRising));

  hctr_host_model host (
    .sys_clk(sys_clk), .spiSeqActive(spiSeqActive), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .startVec(startVec), .doneLat(doneLat), .doneVec(doneVec));

  always #50 sys_clk = ~sys_clk;

  // Edge stamps of sequence end and of each action
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    spiPrev <= spiSeqActive;
    if (spiPrev && !spiSeqActive) tEnd <= cyc;
    if (flagAckPulse) tAck <= cyc;
    if (fifoEmptyPulse) tFifo <= cyc;
    for (int i = 0; i < 3; i++) if (startVec[i]) tGo[i] <= cyc;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (nFail == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk_dflt();
    foreach (dflt[i]) begin
      host.rd(dflt[i].a, d);
      check("default", d, dflt[i].e);
    end
  endtask : chk_dflt

  task automatic wait_idle();
    int i;
    repeat (4) @(posedge sys_clk);
    for (i = 0; i < 200 && cmdBusy !== 1'b0; i++) @(posedge sys_clk);
    if (i == 200) begin
      nFail++;
      complete_run();
    end
  endtask : wait_idle

  task automatic smp(input logic [15:0] v);
    @(posedge sys_clk);
    sampleValid <= 1'b1;
    pressureSample <= v;
    @(posedge sys_clk);
    sampleValid <= 1'b0;
    #1;
  endtask : smp

  task automatic command(input logic [7:0] c);
    host.seq(1'b1);
    host.wr(`HCTR_ADDR_CMD, c);
    host.seq(1'b0);
    wait_idle();
  endtask : command

  initial begin
    sampleValid <= 1'b0;
    fixedCheckEnable <= 1'b0;
    relativeCheckEnable <= 1'b0;
    pressureSample <= 16'h0000;
    relLow <= 8'h00;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    chk_dflt();
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, d);
      check("row", d, rows[i].e);
    end
    // Clamp must wait for the sequence to close
    host.seq(1'b1);
    host.wr(`HCTR_ADDR_DEB, 8'hff);
    host.rd(`HCTR_ADDR_DEB, d);
    check("deb open", d, 8'hff);
    host.seq(1'b0);
    host.rd(`HCTR_ADDR_DEB, d);
    check("deb clamp", d, 8'hfe);
    host.seq(1'b1);
    host.wr(`HCTR_ADDR_CMD, 8'hff);
    host.rd(`HCTR_ADDR_CMD, d);
    check("cmd held", d, 8'h9f);
    host.seq(1'b0);
    repeat (8) @(posedge sys_clk);
    host.rd(`HCTR_ADDR_CMD, d);
    check("cmd mid", d, 8'h0f);
    wait_idle();
    check("ack lag", 8'(tAck - tEnd), 8'h02);
    check("fifo lag", 8'(tFifo - tEnd), 8'h03);
    check("fv lag", 8'(tGo[2] - tEnd), 8'h04);
    check("pst order", 8'(tGo[1] > tGo[2] + 30), 8'h01);
    check("adc order", 8'(tGo[0] > tGo[1] + 30), 8'h01);
    chk_dflt();
    doneLat <= 8'h01;
    command(8'h01);
    check("adc lag", 8'(tGo[0] - tEnd), 8'h02);
    host.rd(`HCTR_ADDR_CMD, d);
    check("adc clear", d, 8'h00);
    host.wr(`HCTR_ADDR_DEB, 8'h02);
    host.wr(`HCTR_ADDR_FIX_HI, 8'h01);
    host.wr(`HCTR_ADDR_FIX_LO, 8'h00);
    @(posedge sys_clk) fixedCheckEnable <= 1'b1;
    foreach (pv[i]) begin
      smp(pv[i]);
      check("fixed flag", {7'h00, fixedLimitFlag}, {7'h00, i > 2});
      if (i > 0) check("rising", {7'h00, pressureRising}, {7'h00, i[0] == 1'b0});
    end
    command(8'h80);
    check("flag ack", {7'h00, fixedLimitFlag}, 8'h00);
    @(posedge sys_clk) fixedCheckEnable <= 1'b0;
    relativeCheckEnable <= 1'b1;
    // Low byte decides: a rise of 0x180 passes 0x105 but not 0x190
    relLow <= 8'h90;
    host.wr(`HCTR_ADDR_DEB, 8'h01);
    host.wr(`HCTR_ADDR_REL_HI, 8'h01);
    foreach (rv[i]) begin
      smp(rv[i]);
      check("rel flag", {7'h00, relativeLimitFlag}, {7'h00, i == 3});
    end
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("flags rst", {6'h00, relativeLimitFlag, fixedLimitFlag}, 8'h00);
    rstn <= 1'b1;
    chk_dflt();
    complete_run();
  end
endmodule : tb

`default_nettype wire
